/* prox_switch_ctrl.sv */
// Output control of an inductive proximity switch: gain table, under-range, overload, LED.
// Assumes conversion and temperature results arrive as one-cycle strobes on CLK_I.
//
// Summary of operation
// - Low Rp in first three results stops oscillation and turns switch on.
// - Later low Rp with under-range enable reports full scale, switch on.
// - Later low Rp without enable holds switch until a fresh valid result.
// - No switch change before the first temperature conversion completes.
// - Oscillator stop is released at once when low Rp clears.
// - Gain table of 47 two-byte entries at 0x00..0x5D, -48 to 136 C.
// - Gain interpolated linearly between 4 degree points, one degree steps.
// - Entry is unsigned 16 bits, gain times 2^16/4.
// - Even index holds gain bits 15..8, odd index bits 7..0.
// - Proximity value readable at 0x7A (high) and 0x7B (low).
// - Temperature readable at 0x79 as degrees plus 64.
// - Default table holds gain 1.0 (0x4000) in every entry; software may rewrite.
// - LED follows switch state, polarity selectable in output setup.
// - LED sink current chosen by one setup bit.
// - LED also signals overload or correction-code fault.
// - LED blinks at 2 Hz while signalling a fault.
// - Transistor drive stays off until the block is operational.
// - Persistent overcurrent enters overload mode pulsing 30 us on.
// - Off time from duty bit 0 of output setup: on/duty minus on.
// - Duty bit clear means 0.1 percent, set means 0.8 percent.
// - Overload mode ends when overcurrent is gone at a retry pulse.
`timescale 1ns/100ps
module prox_switch_ctrl
    import prox_pkg::*;
#(
    parameter int ADDR_W      = 9,
    parameter int OFF_LO      = OFF_LO_CYCLES,
    parameter int OFF_HI      = OFF_HI_CYCLES,
    parameter int BLINK_HALF  = BLINK_HALF_CYCLES,
    parameter logic [15:0] LUT_DEFAULT = LUT_RST
) (
    input  wire logic              CLK_I,
    input  wire logic              RST_B_I,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] AWADDR_I,
    input  wire logic              AWVALID_I,
    output logic                   AWREADY_O,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic [3:0]        WSTRB_I,
    input  wire logic              WVALID_I,
    output logic                   WREADY_O,
    output logic [1:0]             BRESP_O,
    output logic                   BVALID_O,
    input  wire logic              BREADY_I,
    input  wire logic [ADDR_W-1:0] ARADDR_I,
    input  wire logic              ARVALID_I,
    output logic                   ARREADY_O,
    output logic [31:0]            RDATA_O,
    output logic [1:0]             RRESP_O,
    output logic                   RVALID_O,
    input  wire logic              RREADY_I,
    // Sensor front end
    input  wire logic              CONV_DONE_I,
    input  wire logic [15:0]       RP_CODE_I,
    input  wire logic              UNDER_RANGE_I,
    input  wire logic              SWITCH_REQ_I,
    input  wire logic              TEMP_DONE_I,
    input  wire logic [7:0]        TEMP_CODE_I,
    input  wire logic              OVERCURRENT_I,
    input  wire logic              ECC_FAULT_I,
    output logic [15:0]            GAIN_CORRECTION_FACTOR_O,
    output logic                   OSC_STOP_O,
    output logic                   TRANSISTOR_DRIVE_PIN_O,
    output logic                   LED_ON_O,
    output logic                   LED_HIGH_CURRENT_O
);
    logic [15:0] lut_ff [LUT_ENTRIES];
    logic [7:0]  init_ff, final_ff;
    logic        final_seen_ff, temp_done_ff, switch_ff, osc_stop_ff, drive_ff, led_ff;
    logic        blink_ff, led_cur_ff;
    logic [7:0]  temp_ff;
    logic [15:0] prox_ff, gain_ff;
    logic [2:0]  conv_cnt_ff;
    logic [31:0] ovl_cnt_ff, blink_cnt_ff;
    logic [3:0]  persist_ff;
    ovl_e        ovl_ff, nxt_ovl;
    logic        awready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [7:0]  rdata_ff;

    // Effective output setup: final copy once software has written it
    out_setup_s cfg;
    wire [7:0] cfg_raw = final_seen_ff ? final_ff : init_ff;
    assign cfg = '{under_range_en: cfg_raw[BIT_UR_EN], led_current: cfg_raw[BIT_LED_CUR],
                   led_invert: cfg_raw[BIT_LED_INV], duty_sel: cfg_raw[BIT_DUTY]};

    // Write decode; both channels taken together in the ready cycle
    wire [6:0] widx   = AWADDR_I[8:2];
    wire       wr_go  = awready_ff && AWVALID_I && WVALID_I;
    wire       w_lut  = widx <= IDX_LUT_LAST;
    wire       w_ok   = w_lut || widx == IDX_OUT_INIT || widx == IDX_OUT_FINAL;
    wire       wr_en  = wr_go && w_ok && WSTRB_I[0];
    wire [7:0] wbyte  = WDATA_I[7:0];

    // Read decode
    wire [6:0] ridx    = ARADDR_I[8:2];
    wire       rd_go   = arready_ff && ARVALID_I;
    wire       r_lut   = ridx <= IDX_LUT_LAST;
    wire [5:0] rsel    = r_lut ? ridx[6:1] : 6'h00;
    wire [7:0] r_lutb  = ridx[0] ? lut_ff[rsel][7:0] : lut_ff[rsel][15:8];
    wire       r_ok    = r_lut || ridx == IDX_OUT_INIT || ridx == IDX_OUT_FINAL ||
                         ridx == IDX_TEMP || ridx == IDX_PROX_HI || ridx == IDX_PROX_LO;
    wire [7:0] r_byte  = r_lut                  ? r_lutb        :
                         ridx == IDX_OUT_INIT   ? init_ff       :
                         ridx == IDX_OUT_FINAL  ? final_ff      :
                         ridx == IDX_TEMP       ? temp_ff       :
                         ridx == IDX_PROX_HI    ? prox_ff[15:8] :
                         ridx == IDX_PROX_LO    ? prox_ff[7:0]  : 8'h00;

    // Write address/data ready, one cycle when both offered and no response pending
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            awready_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            awready_ff <= AWVALID_I && WVALID_I && !awready_ff && !bvalid_ff;
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= w_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (BREADY_I) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel; unmapped addresses answer SLVERR with zero data
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= 8'h00;
        end else begin
            arready_ff <= ARVALID_I && !arready_ff && !rvalid_ff;
            if (rd_go) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= r_byte;
                rresp_ff  <= r_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (RREADY_I) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Gain table, default content restored by reset, rewritable byte by byte
    for (genvar e = 0; e < LUT_ENTRIES; e++) begin : g_lut
        wire hit = wr_en && w_lut && widx[6:1] == 6'(e);
        always_ff @(posedge CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
                lut_ff[e] <= LUT_DEFAULT;
            end else if (hit && !widx[0]) begin
                lut_ff[e][15:8] <= wbyte;
            end else if (hit) begin
                lut_ff[e][7:0] <= wbyte;
            end
        end
    end

    // Output setup registers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            init_ff       <= OUT_SETUP_RST;
            final_ff      <= OUT_SETUP_RST;
            final_seen_ff <= 1'b0;
        end else if (wr_en && widx == IDX_OUT_INIT) begin
            init_ff <= wbyte;
        end else if (wr_en && widx == IDX_OUT_FINAL) begin
            final_ff      <= wbyte;
            final_seen_ff <= 1'b1;
        end
    end

    // Interpolation: clamp to table span, pick entry pair, weight by degrees
    wire [7:0]  t_clamp = temp_ff < TEMP_CODE_MIN ? TEMP_CODE_MIN :
                          temp_ff > TEMP_CODE_MAX ? TEMP_CODE_MAX : temp_ff;
    wire [7:0]  t_off   = t_clamp - TEMP_CODE_MIN;
    wire [5:0]  i0      = t_off[7:2];
    wire [5:0]  i1      = i0 == 6'(LUT_ENTRIES - 1) ? i0 : i0 + 6'h01;
    wire [1:0]  frac    = t_off[1:0];
    wire [18:0] mix     = 19'(lut_ff[i0]) * 19'(3'h4 - {1'b0, frac}) +
                          19'(lut_ff[i1]) * 19'(frac);
    wire [15:0] gain    = mix[17:2];

    // Temperature capture and applied gain
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            temp_ff      <= TEMP_RST;
            temp_done_ff <= 1'b0;
            gain_ff      <= LUT_RST;
        end else begin
            gain_ff <= gain;
            if (TEMP_DONE_I) begin
                temp_ff      <= TEMP_CODE_I;
                temp_done_ff <= 1'b1;
            end
        end
    end

    // Under-range classification of the current result
    wire ur_early = UNDER_RANGE_I && conv_cnt_ff < CONV_EARLY;
    wire ur_full  = UNDER_RANGE_I && !ur_early && cfg.under_range_en;
    wire ur_hold  = UNDER_RANGE_I && !ur_early && !cfg.under_range_en;

    // Switch decision, proximity value and result counter
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            conv_cnt_ff <= 3'h0;
            switch_ff   <= 1'b0;
            prox_ff     <= PROX_RST;
        end else if (CONV_DONE_I) begin
            if (conv_cnt_ff != CONV_SAT) begin
                conv_cnt_ff <= conv_cnt_ff + 3'h1;
            end
            prox_ff <= ur_full ? FULL_SCALE : RP_CODE_I;
            if (!temp_done_ff || ur_hold) begin
                switch_ff <= switch_ff;
            end else if (ur_early || ur_full) begin
                switch_ff <= 1'b1;
            end else begin
                switch_ff <= SWITCH_REQ_I;
            end
        end
    end

    // Oscillator stop follows the low Rp level so restart is immediate
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            osc_stop_ff <= 1'b0;
        end else begin
            osc_stop_ff <= temp_done_ff && (ur_early || ur_hold);
        end
    end

    // Overload retry sequencer; counts above 4096 cycles come from parameters
    wire [31:0] off_last = cfg.duty_sel ? 32'(OFF_HI - 1) : 32'(OFF_LO - 1);
    wire        on_last  = ovl_cnt_ff == 32'(ON_CYCLES - 1);
    wire        persist  = persist_ff == 4'(OCP_PERSIST_CYCLES);
    always_comb begin
        nxt_ovl = ovl_ff;
        case (ovl_ff)
            OVL_NORMAL:    if (persist) nxt_ovl = OVL_PULSE_OFF;
            OVL_PULSE_OFF: if (ovl_cnt_ff >= off_last) nxt_ovl = OVL_PULSE_ON;
            OVL_PULSE_ON:  if (on_last) begin
                nxt_ovl = OVERCURRENT_I ? OVL_PULSE_OFF : OVL_NORMAL;
            end
            default:       nxt_ovl = OVL_NORMAL;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ovl_ff     <= OVL_NORMAL;
            ovl_cnt_ff <= 32'h0;
            persist_ff <= 4'h0;
        end else begin
            ovl_ff     <= nxt_ovl;
            ovl_cnt_ff <= nxt_ovl != ovl_ff ? 32'h0 : ovl_cnt_ff + 32'h1;
            if (ovl_ff != OVL_NORMAL || !OVERCURRENT_I || !drive_ff) begin
                persist_ff <= 4'h0;
            end else if (!persist) begin
                persist_ff <= persist_ff + 4'h1;
            end
        end
    end

    // Transistor drive held off until a temperature result makes the block live
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= temp_done_ff && (nxt_ovl == OVL_PULSE_ON ||
                        (nxt_ovl == OVL_NORMAL && switch_ff));
        end
    end

    // LED: state indication, or 2 Hz blink while a fault is signalled
    wire fault = ovl_ff != OVL_NORMAL || ECC_FAULT_I;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            blink_cnt_ff <= 32'h0;
            blink_ff     <= 1'b0;
            led_ff       <= 1'b0;
            led_cur_ff   <= 1'b0;
        end else begin
            led_cur_ff <= cfg.led_current;
            if (!fault || blink_cnt_ff == 32'(BLINK_HALF - 1)) begin
                blink_cnt_ff <= 32'h0;
                blink_ff     <= fault && !blink_ff;
            end else begin
                blink_cnt_ff <= blink_cnt_ff + 32'h1;
            end
            led_ff <= fault ? blink_ff : switch_ff ^ cfg.led_invert;
        end
    end

    // Port drivers, all straight from flip-flops
    assign AWREADY_O                = awready_ff;
    assign WREADY_O                 = awready_ff;
    assign BVALID_O                 = bvalid_ff;
    assign BRESP_O                  = bresp_ff;
    assign ARREADY_O                = arready_ff;
    assign RVALID_O                 = rvalid_ff;
    assign RRESP_O                  = rresp_ff;
    assign RDATA_O                  = {24'h000000, rdata_ff};
    assign GAIN_CORRECTION_FACTOR_O = gain_ff;
    assign OSC_STOP_O               = osc_stop_ff;
    assign TRANSISTOR_DRIVE_PIN_O   = drive_ff;
    assign LED_ON_O                 = led_ff;
    assign LED_HIGH_CURRENT_O       = led_cur_ff;

    // Checks on the decision, overload and indication paths
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_early_low;
        CONV_DONE_I && temp_done_ff && UNDER_RANGE_I && conv_cnt_ff < CONV_EARLY;
    endsequence
    sequence s_retry_clear;
        ovl_ff == OVL_PULSE_ON && on_last && !OVERCURRENT_I;
    endsequence

    AST_EARLY_ON: assert property (s_early_low |=> switch_ff && osc_stop_ff)
        else $error("Early low Rp did not close switch");
    AST_FULL_SCALE: assert property (CONV_DONE_I && temp_done_ff && ur_full
        |=> prox_ff == FULL_SCALE && switch_ff)
        else $error("Under-range did not report full scale");
    AST_HOLD: assert property (CONV_DONE_I && temp_done_ff && ur_hold |=> $stable(switch_ff))
        else $error("Switch changed while held");
    AST_NO_TEMP: assert property (!temp_done_ff |=> $stable(switch_ff))
        else $error("Switch changed before temperature result");
    AST_RESUME: assert property (!UNDER_RANGE_I |=> !osc_stop_ff)
        else $error("Oscillator stop not released");
    AST_DRIVE_OFF: assert property (!temp_done_ff |=> !TRANSISTOR_DRIVE_PIN_O)
        else $error("Drive on before operational");
    AST_ON_LEN: assert property (ovl_ff == OVL_PULSE_ON |-> ovl_cnt_ff < 32'(ON_CYCLES))
        else $error("Retry pulse too long");
    AST_EXIT: assert property (s_retry_clear |=> ovl_ff == OVL_NORMAL)
        else $error("Overload not left");
    AST_LED: assert property (!fault |=> LED_ON_O == ($past(switch_ff) ^ $past(cfg.led_invert)))
        else $error("LED does not follow switch");

    // Capture, counter, blink and retry timing; pause ends even if off time shrinks mid-way
    sequence s_off_done;
        ovl_ff == OVL_PULSE_OFF && ovl_cnt_ff >= off_last;
    endsequence
    AST_TEMP_REG: assert property (
        TEMP_DONE_I |=> temp_ff == $past(TEMP_CODE_I))
        else $error("Temperature not captured");
    AST_PROX: assert property (
        CONV_DONE_I && !ur_full |=> prox_ff == $past(RP_CODE_I))
        else $error("Proximity value not captured");
    AST_CNT_SAT: assert property (
        conv_cnt_ff == CONV_SAT |=> conv_cnt_ff == CONV_SAT)
        else $error("Result counter left saturation");
    AST_BLINK: assert property (
        fault && blink_cnt_ff == 32'(BLINK_HALF - 1) |=> blink_ff != $past(blink_ff))
        else $error("Blink did not toggle");
    AST_LED_CUR: assert property (
        1'b1 |=> LED_HIGH_CURRENT_O == $past(cfg.led_current))
        else $error("LED current not following setup");
    AST_OVL_ENTRY: assert property (
        ovl_ff == OVL_NORMAL && persist |=> !TRANSISTOR_DRIVE_PIN_O)
        else $error("Overload did not start with a pause");
    AST_OFF_END: assert property (
        s_off_done |=> ovl_ff == OVL_PULSE_ON && TRANSISTOR_DRIVE_PIN_O)
        else $error("Retry pause did not end");
endmodule

/* prox_pkg.sv */
// Shared constants and types for the proximity switch output control block.
// Assumes a 100 MHz core clock; register indices map to byte addresses index*4.
package prox_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int ON_TIME_NS         = 30000;                    // Overload retry pulse
    localparam int ON_CYCLES          = ON_TIME_NS / CLK_PERIOD_NS;
    localparam int DUTY_LO_PERMILLE   = 1;                        // 0.1 percent
    localparam int DUTY_HI_PERMILLE   = 8;                        // 0.8 percent
    localparam int OFF_LO_CYCLES      = ON_CYCLES * 1000 / DUTY_LO_PERMILLE - ON_CYCLES;
    localparam int OFF_HI_CYCLES      = ON_CYCLES * 1000 / DUTY_HI_PERMILLE - ON_CYCLES;
    localparam int BLINK_RATE_HZ      = 2;
    localparam int BLINK_HALF_CYCLES  = 1000000000 / CLK_PERIOD_NS / (2 * BLINK_RATE_HZ);
    localparam int OCP_PERSIST_CYCLES = 8;                        // Overcurrent must persist

    // Register indices (byte address is index times four)
    localparam logic [6:0] IDX_LUT_LAST  = 7'h5d;
    localparam logic [6:0] IDX_OUT_INIT  = 7'h72;
    localparam logic [6:0] IDX_OUT_FINAL = 7'h78;
    localparam logic [6:0] IDX_TEMP      = 7'h79;
    localparam logic [6:0] IDX_PROX_HI   = 7'h7a;
    localparam logic [6:0] IDX_PROX_LO   = 7'h7b;

    // Output setup register fields
    localparam int BIT_DUTY    = 0;
    localparam int BIT_LED_INV = 1;
    localparam int BIT_LED_CUR = 2;
    localparam int BIT_UR_EN   = 3;
    localparam logic [7:0] OUT_SETUP_RST = 8'h00;

    // Gain table and measurement codes
    localparam int          LUT_ENTRIES   = 47;
    localparam logic [15:0] LUT_RST       = 16'h4000;           // Gain 1.0
    localparam logic [7:0]  TEMP_CODE_MIN = 8'h10;              // -48 C plus 64
    localparam logic [7:0]  TEMP_CODE_MAX = 8'hc8;              // 136 C plus 64
    localparam logic [7:0]  TEMP_RST      = 8'h00;
    localparam logic [15:0] PROX_RST      = 16'h0000;
    localparam logic [15:0] FULL_SCALE    = 16'hffff;
    localparam logic [2:0]  CONV_EARLY    = 3'h3;               // Results counted as early
    localparam logic [2:0]  CONV_SAT      = 3'h4;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic under_range_en;
        logic led_current;
        logic led_invert;
        logic duty_sel;
    } out_setup_s;

    typedef enum logic [1:0] {OVL_NORMAL, OVL_PULSE_ON, OVL_PULSE_OFF} ovl_e;
endpackage

/* prox_front_model.sv */
// Far-side model: tank converter, thermistor and a load that can short.
// Assumes one bench process calls its tasks, right after a clock edge.
`timescale 1ns/100ps
module prox_front_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        drive_i,
    output logic             conv_done_o,
    output logic [15:0]      rp_code_o,
    output logic             under_range_o,
    output logic             switch_req_o,
    output logic             temp_done_o,
    output logic [7:0]       temp_code_o,
    output logic             overcurrent_o
);
    logic shorted_ff;
    // Quiet front end at time zero
    initial begin
        {conv_done_o, rp_code_o, under_range_o, switch_req_o} = '0;
        {temp_done_o, temp_code_o, shorted_ff} = '0;
    end
    // Sense drop exists only while the transistor conducts into a short
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            overcurrent_o <= 1'b0;
        end else begin
            overcurrent_o <= shorted_ff & drive_i;
        end
    end
    // One result strobe; code lines scrambled once it is gone
    task automatic convert(input logic [15:0] rp, input logic ur, input logic sw);
        @(posedge clk_i);
        conv_done_o <= 1'b1;
        rp_code_o <= rp;
        under_range_o <= ur; // Level, follows the tank
        switch_req_o <= sw;
        @(posedge clk_i);
        conv_done_o <= 1'b0;
        rp_code_o <= ~rp;
    endtask
    task automatic temperature(input logic [7:0] t);
        @(posedge clk_i);
        temp_done_o <= 1'b1;
        temp_code_o <= t;
        @(posedge clk_i);
        temp_done_o <= 1'b0;
        temp_code_o <= ~t;
    endtask
    task automatic set_short(input logic s);
        @(posedge clk_i);
        shorted_ff <= s;
    endtask
endmodule

/* tb.sv */
// Self-checking bench for the proximity switch output control block.
// Assumes the far-side model makes all sensor strobes; registers via AXI4-Lite.
`timescale 1ns/100ps
module tb;
    import prox_pkg::*;
    localparam int OFF_LO = 40;
    localparam int OFF_HI = 20;
    localparam int BLK = 10;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [8:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic ecc = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, conv, ur, sw, tdone, ovc;
    logic osc, drive, led, ledhi;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] rp, rp_code, gain, a, d, b;
    logic [7:0] tcode;
    int mismatches = 0, check_count = 0, seed = 56177, n, f;

    always #5 clk = ~clk;

    prox_switch_ctrl #(.OFF_LO(OFF_LO), .OFF_HI(OFF_HI), .BLINK_HALF(BLK)) prox_switch_ctrl_i (
        .CLK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
        .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .CONV_DONE_I(conv),
        .RP_CODE_I(rp_code), .UNDER_RANGE_I(ur), .SWITCH_REQ_I(sw), .TEMP_DONE_I(tdone),
        .TEMP_CODE_I(tcode), .OVERCURRENT_I(ovc), .ECC_FAULT_I(ecc),
        .GAIN_CORRECTION_FACTOR_O(gain), .OSC_STOP_O(osc), .TRANSISTOR_DRIVE_PIN_O(drive),
        .LED_ON_O(led), .LED_HIGH_CURRENT_O(ledhi));

    prox_front_model prox_front_model_i (
        .clk_i(clk), .rst_b_i(rst_b), .drive_i(drive), .conv_done_o(conv),
        .rp_code_o(rp_code), .under_range_o(ur), .switch_req_o(sw), .temp_done_o(tdone),
        .temp_code_o(tcode), .overcurrent_o(ovc));

    // Verdict in one place, for the main sequence and the watchdog alike
    task automatic close_out;
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Address and data offered together, held until taken
    task automatic wr(input logic [6:0] idx, input logic [7:0] v, input logic [1:0] er);
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        {awvalid, wvalid, bready} <= 3'b111;
        while (!(awready === 1'b1 && wready === 1'b1)) @(posedge clk);
        {awvalid, wvalid} <= 2'b00;
        while (bvalid !== 1'b1) @(posedge clk);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [6:0] idx, input logic [7:0] v, input logic [1:0] er);
        @(posedge clk);
        araddr <= {idx, 2'b00};
        {arvalid, rready} <= 2'b11;
        while (arready !== 1'b1) @(posedge clk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rready <= 1'b0;
        chk({rresp, rdata}, {er, 24'h0, v});
    endtask
    // Lets strobe effects reach the pins
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Cycles that the LED (sel) or the drive keeps level lvl, capped at 5000
    task automatic span(input bit sel, input logic lvl, output int cnt);
        cnt = 0;
        while (((sel ? led : drive) === lvl) && cnt < 5000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask
    function automatic logic [15:0] exp_gain(input logic [15:0] lo, input logic [15:0] st,
                                             input int fr);
        return 16'(lo + st * fr);
    endfunction

    // Watchdog, well beyond the expected run of some 11000 cycles
    initial begin
        #300000;
        mismatches++;
        close_out;
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk(gain, LUT_RST);
        chk({drive, ledhi}, 2'b00);
        rd(IDX_OUT_INIT, OUT_SETUP_RST, RESP_OKAY);
        rd(IDX_PROX_HI, PROX_RST[15:8], RESP_OKAY);
        rd(7'h60, 8'h00, RESP_SLVERR);
        wr(IDX_TEMP, 8'h55, RESP_SLVERR);
        wr(7'h7f, 8'h55, RESP_SLVERR);
        rd(IDX_TEMP, TEMP_RST, RESP_OKAY);
        prox_front_model_i.convert(16'h1234, 1'b0, 1'b1);
        settle;
        chk(drive, 1'b0);
        prox_front_model_i.temperature(8'h40);
        rd(IDX_TEMP, 8'h40, RESP_OKAY);
        prox_front_model_i.convert(16'h0000, 1'b1, 1'b0);
        settle;
        chk({osc, drive, led}, 3'b111);
        rp = 16'($random(seed));
        prox_front_model_i.convert(rp, 1'b0, 1'b0);
        settle;
        chk({osc, drive}, 2'b00);
        rd(IDX_PROX_HI, rp[15:8], RESP_OKAY);
        rd(IDX_PROX_LO, rp[7:0], RESP_OKAY);
        prox_front_model_i.convert(rp, 1'b0, 1'b0);
        prox_front_model_i.convert(rp, 1'b1, 1'b1);
        settle;
        chk({osc, drive}, 2'b10);
        prox_front_model_i.convert(rp, 1'b0, 1'b1);
        settle;
        chk(drive, 1'b1);
        wr(IDX_OUT_INIT, 8'h08, RESP_OKAY);
        prox_front_model_i.convert(rp, 1'b0, 1'b0);
        prox_front_model_i.convert(rp, 1'b1, 1'b0);
        settle;
        chk(drive, 1'b1);
        rd(IDX_PROX_HI, FULL_SCALE[15:8], RESP_OKAY);
        rd(IDX_PROX_LO, FULL_SCALE[7:0], RESP_OKAY);
        wr(IDX_OUT_FINAL, 8'h06, RESP_OKAY);
        settle;
        chk({led, ledhi}, 2'b01);
        rd(IDX_OUT_INIT, 8'h08, RESP_OKAY);
        // Fault blink on the LED
        @(posedge clk) ecc <= 1'b1;
        span(1'b1, led, n);
        span(1'b1, led, n);
        chk(n, BLK);
        @(posedge clk) ecc <= 1'b0;
        // Two random table points one step of four degrees apart
        a = 16'h2000 + (16'($random(seed)) & 16'h0fff);
        d = 16'($random(seed)) & 16'h03ff;
        b = exp_gain(a, d, 4);
        wr(7'd20, a[15:8], RESP_OKAY);
        wr(7'd21, a[7:0], RESP_OKAY);
        wr(7'd22, b[15:8], RESP_OKAY);
        wr(7'd23, b[7:0], RESP_OKAY);
        rd(7'd21, a[7:0], RESP_OKAY);
        rd(7'd0, LUT_RST[15:8], RESP_OKAY);
        rd(IDX_LUT_LAST, LUT_RST[7:0], RESP_OKAY);
        for (f = 0; f <= 4; f++) begin
            prox_front_model_i.temperature(8'h38 + 8'(f));
            settle;
            chk(gain, exp_gain(a, d, f));
        end
        // Overload retry with both duty settings, then recovery
        prox_front_model_i.set_short(1'b1);
        span(1'b0, 1'b1, n);
        span(1'b0, 1'b0, n);
        chk(n, OFF_LO);
        span(1'b0, 1'b1, n);
        chk(n, ON_CYCLES);
        wr(IDX_OUT_FINAL, 8'h07, RESP_OKAY);
        span(1'b0, 1'b0, n);
        span(1'b0, 1'b1, n);
        span(1'b0, 1'b0, n);
        chk(n, OFF_HI);
        prox_front_model_i.set_short(1'b0);
        span(1'b0, 1'b1, n);
        chk(n, 5000);
        close_out;
    end
endmodule
